// ==== core/safety_eval_pkg.sv ====
// Package: constants, types and register map of the safety input evaluator
//
// Overview of operation
// [R1] Single-channel: result follows the input bit when no fault is flagged.
// [R2] Internal fault flag forces every result to zero.
// [R3] Dual equivalent: result one only when both inputs are one.
// [R4] Dual complementary: result one only for first one, second zero.
// [R5] Two-pair equivalent: enable only when all four inputs are one.
// [R6] Two-pair complementary: enable only for pattern 1,0,1,0.
// [R7] Each block input selects one of five evaluation types.
// [R8] Program holds at most 32 function blocks.
// [R9] Program runs in a fixed cycle, constant response time.
// [R10] Logic blocks: inputs, one result, no parameters.
// [R11] Application blocks: inputs, outputs, configurable parameters.
// [R12] One result drives any block inputs but one physical output.
// [R13] Door switches: complementary pairs, discrepancy monitoring, 800 ms.
// [R14] Discrepancy too long sets an error and holds result at zero.
// [R15] Results recomputed once per logic cycle from sampled inputs.
package safety_eval_pkg;
  localparam int unsigned NUM_BLOCKS    = 32;
  localparam int unsigned BLK_W         = 5;
  localparam int unsigned CLK_MHZ       = 200;
  localparam int unsigned DISC_DEF_MS   = 800;
  localparam int unsigned CYC_PER_MS    = CLK_MHZ * 1000;
  localparam logic [15:0] CYCLE_DEF     = 16'h0040;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_CYCLE      = 8'h04;
  localparam logic [7:0] OFS_DISC_MS    = 8'h08;
  localparam logic [7:0] OFS_INPUTS     = 8'h0C;
  localparam logic [7:0] OFS_RESULT     = 8'h10;
  localparam logic [7:0] OFS_DISC_ERR   = 8'h14;
  localparam logic [7:0] OFS_STATUS     = 8'h18;
  localparam logic [7:0] OFS_ROUTE      = 8'h1C;
  localparam logic [7:0] OFS_CFG0       = 8'h80;
  // Control register fields
  localparam int unsigned CTRL_RUN      = 0;
  localparam int unsigned CTRL_FAULT    = 1;
  localparam int unsigned CTRL_DCLR     = 2;
  // Block configuration word fields
  localparam int unsigned CFG_TYPE_LO   = 0;
  localparam int unsigned CFG_EN        = 3;
  localparam int unsigned CFG_DMON      = 4;
  localparam int unsigned CFG_IDX_LO    = 8;
  localparam int unsigned CFG_PHYS_LO   = 16;
  localparam int unsigned CFG_PHYS_EN   = 21;
  localparam logic [31:0] CFG_RESET     = 32'h0000_0000;

  typedef enum logic [2:0] {
    EV_SINGLE, EV_DUAL_EQ, EV_DUAL_CMP, EV_PAIR_EQ, EV_PAIR_CMP
  } eval_type_t;

  typedef struct packed {
    logic [1:0]       htrans;
    logic [31:0]      haddr;
    logic             hwrite;
    logic [2:0]       hsize;
    logic             hsel;
    logic             hready;
    logic [31:0]      hwdata;
  } ahb_req_t;

  typedef struct packed {
    logic [31:0]      hrdata;
    logic             hreadyout;
    logic             hresp;
  } ahb_rsp_t;
endpackage

// ==== core/safety_input_channel_evaluator.sv ====
// Safety input channel evaluator with AHB-Lite register access
`timescale 1ns/1ps
`default_nettype none
module safety_input_channel_evaluator (
  input  wire logic                      hclk,        // 200 MHz clock
  input  wire logic                      hresetn,     // Async reset, active low
  input  wire safety_eval_pkg::ahb_req_t bus_req,     // AHB-Lite request
  output safety_eval_pkg::ahb_rsp_t      bus_rsp,     // AHB-Lite response
  input  wire logic [127:0]              chan_in,     // Sensor channel bits
  input  wire logic                      engine_fault, // Fault from logic engine
  output logic [31:0]                    result,      // Per-block results
  output logic [31:0]                    phys_out,    // Physical outputs
  output logic                           fault_flag,  // Internal fault flag
  output logic                           cycle_tick   // Logic cycle boundary
);
  import safety_eval_pkg::*;

  logic [31:0] cfg_q [NUM_BLOCKS];
  logic [31:0] ctrl_q;
  logic [15:0] cycle_len_q;
  logic [15:0] disc_ms_q;
  logic [15:0] cyc_cnt_q;
  logic [127:0] samp_q;
  logic [31:0] result_q;
  logic [31:0] derr_q;
  logic [31:0] raw;
  logic [31:0] mism;
  logic [31:0] derr_set;
  logic [31:0] phys_d;
  logic [31:0] route_conf_q;
  logic        fault_q;
  logic        tick;
  logic [31:0] disc_lim;
  logic [31:0] disc_cnt_q [NUM_BLOCKS];

  // AHB-Lite slave, zero wait states
  logic        ap_wr_q;
  logic [7:0]  ap_addr_q;
  logic        ap_valid;
  logic [7:0]  ra;
  logic [31:0] rdata;
  logic [31:0] hrdata_q;
  logic        dclr;

  assign ap_valid = bus_req.hsel && bus_req.hready && bus_req.htrans[1];
  assign ra       = bus_req.haddr[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_q   <= 1'b0;
      ap_addr_q <= 8'h00;
    end else begin
      ap_wr_q   <= ap_valid && bus_req.hwrite;
      ap_addr_q <= bus_req.haddr[7:0];
    end
  end

  assign dclr = ap_wr_q && (ap_addr_q == OFS_CTRL) && bus_req.hwdata[CTRL_DCLR];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q      <= 32'h0000_0001;
      cycle_len_q <= CYCLE_DEF;
      disc_ms_q   <= 16'(DISC_DEF_MS);
    end else if (ap_wr_q) begin
      case (ap_addr_q)
        OFS_CTRL:    ctrl_q      <= {29'h0000_0000, 1'b0, bus_req.hwdata[1:0]};
        OFS_CYCLE:   cycle_len_q <= (bus_req.hwdata[15:0] == 16'h0000) ? 16'h0001
                                                                      : bus_req.hwdata[15:0];
        OFS_DISC_MS: disc_ms_q   <= bus_req.hwdata[15:0];
        default:     ;
      endcase
    end
  end

  // Block configuration table, one word per block
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_BLOCKS; i++) cfg_q[i] <= CFG_RESET;
    end else if (ap_wr_q && ap_addr_q[7]) begin
      cfg_q[ap_addr_q[6:2]] <= bus_req.hwdata; // see [R7] [R8] [R10] [R11]
    end
  end

  always_comb begin
    rdata = 32'h0000_0000;
    // Decoded in the address phase so hrdata stands through the data phase;
    // a read right behind a write to the same register returns the old value
    if (ra[7]) begin
      rdata = cfg_q[ra[6:2]];
    end else begin
      case (ra)
        OFS_CTRL:     rdata = ctrl_q;
        OFS_CYCLE:    rdata = {16'h0000, cycle_len_q};
        OFS_DISC_MS:  rdata = {16'h0000, disc_ms_q};
        OFS_INPUTS:   rdata = samp_q[31:0];
        OFS_RESULT:   rdata = result_q;
        OFS_DISC_ERR: rdata = derr_q;
        OFS_STATUS:   rdata = {30'h0000_0000, fault_q, ctrl_q[CTRL_RUN]};
        OFS_ROUTE:    rdata = route_conf_q;
        default:      rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata_q <= 32'h0000_0000;
    else if (ap_valid && !bus_req.hwrite) hrdata_q <= rdata;
  end
  assign bus_rsp = '{hrdata: hrdata_q, hreadyout: 1'b1, hresp: 1'b0};

  // Fixed logic cycle, independent of input values
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cyc_cnt_q <= 16'h0000;
    else if (tick || !ctrl_q[CTRL_RUN]) cyc_cnt_q <= 16'h0000;
    else cyc_cnt_q <= cyc_cnt_q + 16'h0001; // see [R9]
  end
  // Compare with >= so a shortened cycle ends at once instead of wrapping
  assign tick = ctrl_q[CTRL_RUN] && (cyc_cnt_q >= cycle_len_q - 16'h0001);

  // Sample inputs once per cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) samp_q <= 128'h0;
    else if (tick) samp_q <= chan_in; // see [R15]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) fault_q <= 1'b0;
    else fault_q <= engine_fault || ctrl_q[CTRL_FAULT]; // see [R2]
  end

  assign disc_lim = 32'(disc_ms_q) * 32'(CYC_PER_MS);

  // Per-block evaluation, four channel bits per block
  for (genvar b = 0; b < NUM_BLOCKS; b++) begin : g_blk
    logic [3:0] in4;
    logic [2:0] ty;
    assign in4 = samp_q[4*cfg_q[b][CFG_IDX_LO +: BLK_W] +: 4];
    assign ty  = cfg_q[b][CFG_TYPE_LO +: 3];
    always_comb begin
      raw[b]  = 1'b0;
      mism[b] = 1'b0;
      case (ty)
        EV_SINGLE:   raw[b] = in4[0]; // see [R1]
        EV_DUAL_EQ: begin
          raw[b]  = in4[0] & in4[1]; // see [R3]
          mism[b] = in4[0] ^ in4[1];
        end
        EV_DUAL_CMP: begin
          raw[b]  = in4[0] & ~in4[1]; // see [R4]
          mism[b] = ~(in4[0] ^ in4[1]);
        end
        EV_PAIR_EQ: begin
          raw[b]  = &in4; // see [R5]
          mism[b] = (in4[0] ^ in4[1]) | (in4[2] ^ in4[3]);
        end
        EV_PAIR_CMP: begin
          raw[b]  = in4 == 4'b0101; // see [R6]
          mism[b] = ~(in4[0] ^ in4[1]) | ~(in4[2] ^ in4[3]);
        end
        default:     raw[b] = 1'b0;
      endcase
    end
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) disc_cnt_q[b] <= 32'h0000_0000;
      else if (!mism[b] || !cfg_q[b][CFG_DMON]) disc_cnt_q[b] <= 32'h0000_0000;
      else if (disc_cnt_q[b] <= disc_lim) disc_cnt_q[b] <= disc_cnt_q[b] + 32'h0000_0001;
    end
    assign derr_set[b] = cfg_q[b][CFG_DMON] && (disc_cnt_q[b] > disc_lim); // see [R14]
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) derr_q[b] <= 1'b0;
      else if (derr_set[b]) derr_q[b] <= 1'b1;
      else if (dclr && bus_req.hwdata[8 + (b % 24)] == 1'b0) derr_q[b] <= derr_q[b];
      else if (dclr) derr_q[b] <= 1'b0;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) result_q[b] <= 1'b0;
      else if (fault_q) result_q[b] <= 1'b0; // see [R2]
      else if (tick) result_q[b] <= raw[b] && cfg_q[b][CFG_EN] && !derr_q[b]; // see [R14]
    end
  end

  // Physical output routing: one result to one output per block
  always_comb begin
    phys_d = 32'h0000_0000;
    for (int i = 0; i < NUM_BLOCKS; i++) begin
      if (cfg_q[i][CFG_PHYS_EN])
        phys_d[cfg_q[i][CFG_PHYS_LO +: BLK_W]] = phys_d[cfg_q[i][CFG_PHYS_LO +: BLK_W]]
                                                | result_q[i]; // see [R12]
    end
  end

  // Flags physical outputs claimed by more than one block
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) route_conf_q <= 32'h0000_0000;
    else begin
      for (int o = 0; o < NUM_BLOCKS; o++) begin
        int unsigned n;
        n = 0;
        for (int i = 0; i < NUM_BLOCKS; i++)
          if (cfg_q[i][CFG_PHYS_EN] && cfg_q[i][CFG_PHYS_LO +: BLK_W] == BLK_W'(o)) n++;
        route_conf_q[o] <= n > 1; // see [R12]
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) phys_out <= 32'h0000_0000;
    else phys_out <= phys_d & ~route_conf_q;
  end

  assign result     = result_q;
  assign fault_flag = fault_q;
  assign cycle_tick = tick;

  // Steps shared by the properties below
  sequence s_tick_gap;
    !tick [*3] ##1 tick;
  endsequence

  sequence s_mism_start;
    mism[1] && cfg_q[1][CFG_DMON] && disc_lim == 32'h0000_0000;
  endsequence

  // Result and fault behaviour
  a_fault_zero: assert property (@(posedge hclk) disable iff (!hresetn) // see [R2]
    fault_q
    |=> result_q == 32'h0000_0000)
    else $error("Result not zero under fault");
  a_fault_follow: assert property (@(posedge hclk) disable iff (!hresetn) // see [R2]
    1'b1
    |=> fault_q == $past(engine_fault || ctrl_q[CTRL_FAULT]))
    else $error("Fault flag did not follow its sources");
  a_result_hold: assert property (@(posedge hclk) disable iff (!hresetn) // see [R15]
    !tick && !$past(fault_q) && !fault_q
    |=> $stable(result_q))
    else $error("Result changed between cycles");
  a_samp_hold: assert property (@(posedge hclk) disable iff (!hresetn) // see [R15]
    !tick
    |=> $stable(samp_q))
    else $error("Inputs sampled between cycles");

  // Fixed logic cycle
  a_tick_period: assert property (@(posedge hclk) disable iff (!hresetn) // see [R9]
    tick && cycle_len_q == 16'h0004 && $stable(cycle_len_q)
    |=> s_tick_gap)
    else $error("Cycle length wrong");
  a_tick_clear: assert property (@(posedge hclk) disable iff (!hresetn) // see [R9]
    tick
    |=> cyc_cnt_q == 16'h0000)
    else $error("Cycle counter not restarted");

  // Evaluation types, one block each
  a_single_eval: assert property (@(posedge hclk) disable iff (!hresetn) // see [R1]
    tick && !fault_q && cfg_q[0][2:0] == 3'(EV_SINGLE) && cfg_q[0][CFG_EN] && !derr_q[0]
    |=> result_q[0] == $past(samp_q[4*cfg_q[0][12:8]]))
    else $error("Single eval wrong");
  a_dual_eq: assert property (@(posedge hclk) disable iff (!hresetn) // see [R3]
    cfg_q[1][2:0] == 3'(EV_DUAL_EQ)
    |-> raw[1] == (g_blk[1].in4[1:0] == 2'b11))
    else $error("Dual equivalent wrong");
  a_dual_cmp: assert property (@(posedge hclk) disable iff (!hresetn) // see [R4]
    cfg_q[2][2:0] == 3'(EV_DUAL_CMP)
    |-> raw[2] == (g_blk[2].in4[1:0] == 2'b01))
    else $error("Dual complementary wrong");
  a_pair_eq: assert property (@(posedge hclk) disable iff (!hresetn) // see [R5]
    cfg_q[3][2:0] == 3'(EV_PAIR_EQ)
    |-> raw[3] == (g_blk[3].in4 == 4'b1111))
    else $error("Pair equivalent wrong");
  a_pair_cmp: assert property (@(posedge hclk) disable iff (!hresetn) // see [R6]
    cfg_q[4][2:0] == 3'(EV_PAIR_CMP)
    |-> raw[4] == (g_blk[4].in4 == 4'b0101))
    else $error("Pair complementary wrong");

  // Discrepancy monitoring on block 1
  a_disc_hold: assert property (@(posedge hclk) disable iff (!hresetn) // see [R14]
    derr_q[1] && tick
    |=> !result_q[1])
    else $error("Discrepancy did not block");
  a_disc_fast: assert property (@(posedge hclk) disable iff (!hresetn) // see [R14]
    s_mism_start ##1 (cfg_q[1][CFG_DMON] && disc_lim == 32'h0000_0000)
    |=> derr_q[1])
    else $error("Discrepancy error not raised");
  a_derr_sticky: assert property (@(posedge hclk) disable iff (!hresetn) // see [R14]
    derr_q[1] && !dclr
    |=> derr_q[1])
    else $error("Discrepancy error lost without clear");

  // Routing and register bus
  a_route_block: assert property (@(posedge hclk) disable iff (!hresetn) // see [R12]
    1'b1
    |=> (phys_out & $past(route_conf_q)) == 32'h0000_0000)
    else $error("Shared physical output driven");
  a_rdata_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !(ap_valid && !bus_req.hwrite)
    |=> $stable(bus_rsp.hrdata))
    else $error("Read data changed without a read");
  a_disc_write: assert property (@(posedge hclk) disable iff (!hresetn) // see [R14]
    ap_wr_q && ap_addr_q == OFS_DISC_MS
    |=> disc_ms_q == $past(bus_req.hwdata[15:0]))
    else $error("Discrepancy time write lost");
endmodule // safety_input_channel_evaluator
`default_nettype wire

// ==== testbench/sensor_model.sv ====
// Sensor field model: presents contact patterns to the evaluator channels
`timescale 1ns/1ps
`default_nettype none
module sensor_model #(
  parameter int LAG = 2
) (
  input  wire logic         hclk,    // Bench clock
  input  wire logic         hresetn, // Reset, active low
  input  wire logic [127:0] pattern, // Requested contact states
  output logic      [127:0] chan_in  // Channel bits to the evaluator
);
  logic [127:0] pipe_q [LAG];
  // Contacts settle a few cycles after the actuator moves
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < LAG; i++) pipe_q[i] <= '0;
    end else begin
      pipe_q[0] <= pattern;
      for (int i = 1; i < LAG; i++) pipe_q[i] <= pipe_q[i-1];
    end
  end
  assign chan_in = pipe_q[LAG-1];
endmodule // sensor_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the safety input channel evaluator
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %0t: got %h exp %h", $time, g, e); end end
module tb_top;
  import safety_eval_pkg::*;
  typedef struct packed { logic rd; logic [63:0] v; } note_t;
  logic         hclk = 1'b0;
  logic         hresetn = 1'b0;
  logic [1:0]   htrans = 2'b00;
  logic [31:0]  haddr = '0;
  logic         hwrite = 1'b0;
  logic [31:0]  hwdata = '0;
  logic [127:0] pat = '0;
  logic         efault = 1'b0;
  logic [127:0] chan_in;
  logic [31:0]  result, phys_out, obs, hold_m;
  logic         fault_flag, cycle_tick;
  ahb_req_t     bus_req;
  ahb_rsp_t     bus_rsp;
  note_t        notes[$];
  event         chk;
  int           fails = 0;
  int           tests_run = 0;

  always #2.5 hclk = ~hclk;
  assign bus_req = '{htrans: htrans, haddr: haddr, hwrite: hwrite, hsize: 3'b010,
                     hsel: 1'b1, hready: bus_rsp.hreadyout, hwdata: hwdata};
  sensor_model #(.LAG(2)) sens (.hclk(hclk), .hresetn(hresetn), .pattern(pat),
    .chan_in(chan_in));
  safety_input_channel_evaluator dut (.hclk(hclk), .hresetn(hresetn), .bus_req(bus_req),
    .bus_rsp(bus_rsp), .chan_in(chan_in), .engine_fault(efault), .result(result),
    .phys_out(phys_out), .fault_flag(fault_flag), .cycle_tick(cycle_tick));

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge hclk);
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    do begin @(posedge hclk); n++; end while (bus_rsp.hreadyout !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge hclk); n++; end while (bus_rsp.hreadyout !== 1'b1 && n < 50);
    obs = bus_rsp.hrdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    notes.push_back('{1'b1, {32'h0000_0000, e}});
    ahb(1'b0, a, 32'h0000_0000);
    ->chk;
  endtask

  // Waits for k logic cycle boundaries, bounded in case the tick never comes
  task automatic ticks(input int k);
    int n;
    n = 0;
    while (k > 0 && n < 2000) begin
      @(posedge hclk);
      n++;
      if (cycle_tick === 1'b1) k--;
    end
    repeat (3) @(posedge hclk);
  endtask

  function automatic logic ev(input int t, input logic [3:0] g);
    case (t)
      0: return g[0];
      1: return g[0] & g[1];
      2: return g[0] & ~g[1];
      3: return &g;
      default: return g == 4'b0101;
    endcase
  endfunction

  // Block b reads group b and drives physical output b
  task automatic apply(input logic [127:0] p, input logic ef, input logic z);
    logic [31:0] e;
    pat <= p;
    efault <= ef;
    for (int b = 0; b < 32; b++) e[b] = !(ef || z) && ev(b % 5, p[4*b +: 4]);
    ticks(3);
    notes.push_back('{1'b0, {e & hold_m, e & hold_m}});
    ->chk;
  endtask

  initial forever begin
    note_t n;
    @(chk);
    n = notes.pop_front();
    if (n.rd) `CHK(obs, n.v[31:0])
    else `CHK({phys_out, result}, n.v)
  end

  // About 670 cycles of tests; over 25 times that before giving up
  initial begin
    #100us;
    fails++;
    $display("unexpected %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    logic [31:0] c;
    void'($urandom(35324));
    hold_m = '1;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd(OFS_STATUS, 32'h0000_0001);
    rd(OFS_CYCLE, 32'h0000_0040);
    rd(OFS_DISC_MS, 32'h0000_0320);
    rd(OFS_CFG0, CFG_RESET);
    rd(8'h40, 32'h0000_0000);
    ahb(1'b1, OFS_CYCLE, 32'h0000_0004);
    rd(OFS_CYCLE, 32'h0000_0004);
    for (int b = 0; b < 32; b++) begin
      c = (b % 5) | 32'h0020_0008 | (b << 8) | (b << 16);
      ahb(1'b1, OFS_CFG0 + 8'(4 * b), c);
    end
    for (int v = 0; v < 16; v++) apply({32{4'(v)}}, 1'b0, 1'b0);
    repeat (20) apply({$urandom, $urandom, $urandom, $urandom}, 1'b0, 1'b0);
    apply('1, 1'b1, 1'b0);
    ahb(1'b1, OFS_CTRL, 32'h0000_0003);
    rd(OFS_STATUS, 32'h0000_0003);
    apply('1, 1'b0, 1'b1);
    ahb(1'b1, OFS_CTRL, 32'h0000_0001);
    apply('1, 1'b0, 1'b0);
    // Block 1 with discrepancy monitoring and zero time; channels disagree
    ahb(1'b1, OFS_DISC_MS, 32'h0000_0000);
    ahb(1'b1, OFS_CFG0 + 8'h04, 32'h0021_0119);
    apply({{120{1'b1}}, 8'h2F}, 1'b0, 1'b0);
    rd(OFS_DISC_ERR, 32'h0000_0002);
    hold_m = 32'hFFFF_FFFD;
    apply('1, 1'b0, 1'b0);
    ahb(1'b1, OFS_CTRL, 32'h0000_0205);
    hold_m = '1;
    apply('1, 1'b0, 1'b0);
    rd(OFS_DISC_ERR, 32'h0000_0000);
    rd(OFS_INPUTS, 32'hFFFF_FFFF);
    rd(OFS_ROUTE, 32'h0000_0000);
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
